// ---- mrpc_chain.sv ----
// output macrocell registers with power-up clear and serial preload chain
`timescale 1ns/100ps
module mrpc_chain
  import mrpc_pkg::*;
#(
  parameter int N = MRPC_NUM_CELLS,
  parameter int CLEAR_CYCLES = MRPC_CLEAR_CYCLES
)
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic preload_select_in,
  input wire logic preload_shift_clock_in,
  input wire logic serial_load_in,
  output logic serial_state_out,
  output logic serial_state_oe_out,
  output logic serial_state_valid_out,
  input wire logic serial_state_ready_in,
  input wire logic sync_mode_cell_in,
  input wire logic global_arch_cell_in,
  input wire logic [N-1:0] local_arch_cell_in,
  input wire logic [N-1:0] polarity_cell_in,
  input wire logic global_oe_n_in,
  input wire logic [N-1:0] sum_term_in,
  input wire logic [N-1:0] oe_term_in,
  input wire logic [N-1:0] pin_level_in,
  output logic [N-1:0] pin_out,
  output logic [N-1:0] pin_oe_out,
  output logic [2*N-1:0] array_line_out,
  output logic power_up_done_out,
  output logic preload_active_out,
  output logic [$clog2(N+1)-1:0] chain_length_out
);
  import mrpc_pkg::*;

  localparam int CLW = $clog2(N + 1);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [N+3:0] raw_pins;
  logic [N+3:0] sync_pins;
  logic preload_s;
  logic sclk_s;
  logic serial_load_in_s;
  logic goe_n_s;
  logic [N-1:0] pins_s;
  logic sclk_d;

  assign raw_pins = {pin_level_in, global_oe_n_in, serial_load_in, preload_shift_clock_in, preload_select_in};
  assign preload_s = sync_pins[0];
  assign sclk_s = sync_pins[1];
  assign serial_load_in_s = sync_pins[2];
  assign goe_n_s = sync_pins[3];
  assign pins_s = sync_pins[N+3:4];

  mrpc_sync #(.WIDTH(N + 4)) u_sync (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .async_in(raw_pins),
    .sync_out(sync_pins)
  );

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      sclk_d <= 1'h0;
    else
      sclk_d <= sclk_s;
  end

  wire sclk_rise = sclk_s && !sclk_d;

  // ----------------------------------------------------------------
  // architecture decode
  // ----------------------------------------------------------------
  wire registered_mode = (sync_mode_cell_in == MRPC_SYNC_REGISTERED);
  wire large_mode = (global_arch_cell_in != MRPC_GLOBAL_SMALL);
  logic [N-1:0] reg_mask;
  logic [N-1:0] comb_val;
  logic [N-1:0] next_oe;

  // registered membership decides chain stages
  assign reg_mask = (registered_mode && large_mode) ? ~local_arch_cell_in : '0;
  // polarity acts on the function ahead of the register
  assign comb_val = sum_term_in ^ ~polarity_cell_in;

  always_comb
  begin
    next_oe = '0;
    if (!large_mode)
      next_oe = ~local_arch_cell_in;
    else
    begin
      for (int i = 0; i < N; i++)
        next_oe[i] = reg_mask[i] ? (registered_mode && !goe_n_s) : oe_term_in[i];
    end
  end

  // ----------------------------------------------------------------
  // mode sequencing and power-up clear
  // ----------------------------------------------------------------
  mrpc_mode_t mode;
  mrpc_mode_t next_mode;
  logic [MRPC_CLEAR_CNT_W-1:0] clr_cnt;
  wire clr_done = (clr_cnt >= MRPC_CLEAR_CNT_W'(CLEAR_CYCLES - 1));

  always_comb
  begin
    next_mode = mode;
    unique case (mode)
      MRPC_MODE_CLEAR: if (clr_done) next_mode = MRPC_MODE_NORMAL;
      // elevated level qualifies entry, removal ends it
      MRPC_MODE_NORMAL: if (preload_s) next_mode = MRPC_MODE_PRELOAD;
      MRPC_MODE_PRELOAD: if (!preload_s) next_mode = MRPC_MODE_NORMAL;
      default: next_mode = MRPC_MODE_CLEAR;
    endcase
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      mode <= MRPC_MODE_CLEAR;
      clr_cnt <= '0;
    end
    else
    begin
      mode <= next_mode;
      if (!clr_done)
        clr_cnt <= clr_cnt + 1'h1;
    end
  end

  // ----------------------------------------------------------------
  // chain shift
  // ----------------------------------------------------------------
  function automatic logic [N:0] mrpc_shift(input logic [N-1:0] q, input logic [N-1:0] m, input logic din);
    logic carry;
    logic [N-1:0] nq;
    carry = din;
    nq = q;
    for (int i = 0; i < N; i++)
    begin
      if (m[i])
      begin
        nq[i] = carry;
        carry = q[i];
      end
    end
    return {carry, nq};
  endfunction : mrpc_shift

  logic [N-1:0] reg_q;
  logic [N:0] shifted;
  logic buf_ready;
  logic buf_valid;
  logic buf_data;

  assign shifted = mrpc_shift(reg_q, reg_mask, serial_load_in_s);
  // shift only when the readback buffer can take the bit out, never on oe state
  wire shift_en = (mode == MRPC_MODE_PRELOAD) && preload_s && sclk_rise && buf_ready;
  wire load_en = (mode == MRPC_MODE_NORMAL) && !preload_s && sclk_rise;

  always_ff @(posedge clk_in)
  begin
    if (rst_in || mode == MRPC_MODE_CLEAR)
      reg_q <= {N{MRPC_REG_RESET}};
    else if (shift_en)
      reg_q <= shifted[N-1:0];
    else if (load_en)
      reg_q <= (reg_q & ~reg_mask) | (comb_val & reg_mask);
  end

  mrpc_buf2 #(.WIDTH(1)) u_buf (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .in_valid_in(shift_en),
    .in_data_in(shifted[N]),
    .in_ready_out(buf_ready),
    .out_valid_out(buf_valid),
    .out_data_out(buf_data),
    .out_ready_in(serial_state_ready_in)
  );

  assign serial_state_out = buf_data;
  assign serial_state_valid_out = buf_valid;
  // open drain: pull low only for a 0 while in preload
  assign serial_state_oe_out = (mode == MRPC_MODE_PRELOAD) && buf_valid && !buf_data;

  // ----------------------------------------------------------------
  // output pins and array lines
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < N; g++)
    begin : g_lines
      always_ff @(posedge clk_in)
      begin
        if (rst_in)
          array_line_out[2*g+1:2*g] <= 2'h1;
        else
          array_line_out[2*g+1:2*g] <= {~pins_s[g], pins_s[g]};
      end
    end
  endgenerate

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      pin_out <= '0;
      pin_oe_out <= '0;
      chain_length_out <= '0;
      power_up_done_out <= 1'h0;
      preload_active_out <= 1'h0;
    end
    else
    begin
      pin_out <= (~reg_q & reg_mask) | (comb_val & ~reg_mask);
      pin_oe_out <= next_oe;
      chain_length_out <= CLW'($countones(reg_mask));
      power_up_done_out <= (mode != MRPC_MODE_CLEAR);
      preload_active_out <= (mode == MRPC_MODE_PRELOAD);
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  localparam int CLR_MAX = CLEAR_CYCLES + 2;
  // edges since reset release while the clear is still reported running
  logic [MRPC_CLEAR_CNT_W-1:0] clr_wait;

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      clr_wait <= '0;
    else if (!power_up_done_out && clr_wait != '1)
      clr_wait <= clr_wait + 1'h1;
  end
  logic [N-1:0] true_lines;
  logic [N-1:0] comp_lines;

  always_comb
  begin
    true_lines = '0;
    comp_lines = '0;
    for (int i = 0; i < N; i++)
    begin
      true_lines[i] = array_line_out[2*i];
      comp_lines[i] = array_line_out[2*i+1];
    end
  end

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  sequence s_shift_low;
    shift_en && reg_mask[0];
  endsequence
  sequence s_low_took_bit;
    reg_q[0] == $past(serial_load_in_s);
  endsequence

  property p_clear_done;
    !power_up_done_out |-> (reg_q == '0) && (clr_wait <= MRPC_CLEAR_CNT_W'(CLR_MAX));
  endproperty
  a_clear_done: assert property (p_clear_done) else $error("power-up clear too long");

  property p_needs_select;
    shift_en |-> preload_s && (mode == MRPC_MODE_PRELOAD);
  endproperty
  a_needs_select: assert property (p_needs_select) else $error("shift outside preload");

  property p_bypass;
    shift_en && $stable(reg_mask) |=> ((reg_q & ~reg_mask) == ($past(reg_q) & ~reg_mask));
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypassed cell changed");

  property p_hold;
    !shift_en && !load_en && (mode != MRPC_MODE_CLEAR) |=> $stable(reg_q);
  endproperty
  a_hold: assert property (p_hold) else $error("register moved without edge");

  property p_entry;
    s_shift_low |=> s_low_took_bit;
  endproperty
  a_entry: assert property (p_entry) else $error("bit did not enter lowest cell");

  property p_readout;
    shift_en && reg_mask[N-1] && !buf_valid |=> buf_valid && (buf_data == $past(reg_q[N-1]));
  endproperty
  a_readout: assert property (p_readout) else $error("top bit not read out");

  property p_levels;
    serial_state_oe_out |-> !serial_state_out;
  endproperty
  a_levels: assert property (p_levels) else $error("drive low on a one");

  property p_inverted;
    $stable(reg_mask) |=> ((pin_out & $past(reg_mask)) == (~$past(reg_q) & $past(reg_mask)));
  endproperty
  a_inverted: assert property (p_inverted) else $error("output not inverted state");

  property p_oe_free;
    (mode == MRPC_MODE_PRELOAD) && preload_s && sclk_rise && buf_ready |-> shift_en;
  endproperty
  a_oe_free: assert property (p_oe_free) else $error("shift blocked");

  property p_lines;
    ##1 true_lines == ~comp_lines;
  endproperty
  a_lines: assert property (p_lines) else $error("array pair not complementary");

  property p_comb_only;
    !registered_mode |-> (reg_mask == '0);
  endproperty
  a_comb_only: assert property (p_comb_only) else $error("register in combinational mode");

  property p_exit;
    !preload_s && (mode == MRPC_MODE_PRELOAD) |=> (mode == MRPC_MODE_NORMAL) && !shift_en;
  endproperty
  a_exit: assert property (p_exit) else $error("preload not left");

endmodule : mrpc_chain

// ---- mrpc_pkg.sv ----
// constants and types for the macrocell register preload chain
//
// How it works
// - registers clear at power-up, finished within 45 us of supply valid
// - preload mode only while preload_select sits at the elevated level
// - chain holds one stage per registered macrocell; others are bypassed
// - one chain shift per rising shift clock edge while the readback buffer has room, one input bit each
// - bits enter the lowest registered macrocell and move upward
// - old register contents shift up and out on serial_state_out
// - low level means register 0, high level means register 1
// - registered output pins always show the inverted stored bit
// - readback works whatever the output enables are doing
// - any pattern loads, normal clocking then resumes from it
// - each pin gives an even true array line and odd complement line
// - sync_mode_cell 0 registered with clock and oe pins, 1 combinational
// - global_arch_cell 1: local_arch_cell 0 registered, 1 combinational
// - global_arch_cell 0: local_arch_cell 0 output always on, 1 input
// - polarity cell 0 active low, 1 active high at combinational pins, the reverse at registered pins
package mrpc_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int MRPC_CLK_PERIOD_NS = 20;
  localparam int MRPC_CLEAR_TIME_US = 45;
  // longest time, so rounded down
  localparam int MRPC_CLEAR_CYCLES = (MRPC_CLEAR_TIME_US * 1000) / MRPC_CLK_PERIOD_NS;
  localparam int MRPC_CLEAR_CNT_W = 16;

  // ----------------------------------------------------------------
  // sizes and reset values
  // ----------------------------------------------------------------
  localparam int MRPC_NUM_CELLS = 8;
  localparam int MRPC_SYNC_STAGES = 2;
  localparam logic MRPC_REG_RESET = 1'h0;
  localparam logic [1:0] MRPC_BUF_CNT_RESET = 2'h0;
  localparam logic [1:0] MRPC_BUF_FULL = 2'h2;

  // ----------------------------------------------------------------
  // cell encodings
  // ----------------------------------------------------------------
  localparam logic MRPC_SYNC_REGISTERED = 1'h0;
  localparam logic MRPC_GLOBAL_SMALL = 1'h0;
  localparam logic MRPC_LOCAL_REGISTERED = 1'h0;
  localparam logic MRPC_POL_ACTIVE_HIGH = 1'h1;

  typedef enum logic [1:0] {MRPC_MODE_CLEAR, MRPC_MODE_NORMAL, MRPC_MODE_PRELOAD} mrpc_mode_t;

endpackage : mrpc_pkg

// ---- mrpc_sync.sv ----
// two-flop synchroniser for pin inputs
`timescale 1ns/100ps
module mrpc_sync
  import mrpc_pkg::*;
#(
  parameter int WIDTH = 1
)
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      meta <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta <= async_in;
      sync_out <= meta;
    end
  end

endmodule : mrpc_sync

// ---- mrpc_buf2.sv ----
// two-entry buffer with valid and ready on both sides
`timescale 1ns/100ps
module mrpc_buf2
  import mrpc_pkg::*;
#(
  parameter int WIDTH = 1
)
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic in_valid_in,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic in_ready_out,
  output logic out_valid_out,
  output logic [WIDTH-1:0] out_data_out,
  input wire logic out_ready_in
);

  logic [1:0] count;
  logic [WIDTH-1:0] second;
  wire push = in_valid_in && in_ready_out;
  wire pop = out_valid_out && out_ready_in;

  assign in_ready_out = (count != MRPC_BUF_FULL);
  assign out_valid_out = (count != MRPC_BUF_CNT_RESET);

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      count <= MRPC_BUF_CNT_RESET;
      out_data_out <= '0;
      second <= '0;
    end
    else
    begin
      count <= 2'(count + {1'h0, push} - {1'h0, pop});
      if (pop)
        out_data_out <= (count == MRPC_BUF_FULL) ? second : in_data_in;
      else if (push && count == MRPC_BUF_CNT_RESET)
        out_data_out <= in_data_in;
      if (push && (count == MRPC_BUF_FULL - 2'h1) && !pop)
        second <= in_data_in;
      else if (push && count == MRPC_BUF_FULL)
        second <= in_data_in;
    end
  end

endmodule : mrpc_buf2

// ---- mrpc_tester.sv ----
// test equipment model: drives preload pins and collects readback bits
`timescale 1ns/100ps
module mrpc_tester
(
  input wire logic clk_in,
  input wire logic stall_in,
  input wire logic serial_state_oe_in,
  input wire logic serial_state_valid_in,
  output logic preload_select_out,
  output logic preload_shift_clock_out,
  output logic serial_load_out,
  output logic serial_state_ready_out
);
  logic line;
  logic got[$];

  // open drain readback line with pull-up
  assign line = serial_state_oe_in ? 1'h0 : 1'h1;

  initial
  begin
    preload_select_out = 1'h0;
    preload_shift_clock_out = 1'h0;
    serial_load_out = 1'h1;
    serial_state_ready_out = 1'h0;
  end

  always @(negedge clk_in)
    serial_state_ready_out <= ~stall_in;

  always @(posedge clk_in)
  begin
    if (serial_state_valid_in && serial_state_ready_out)
      got.push_back(line);
  end

  task automatic enter(input logic on);
    @(negedge clk_in);
    preload_select_out = on;
    repeat (4) @(negedge clk_in);
  endtask : enter

  task automatic shift_bit(input logic b);
    @(negedge clk_in);
    serial_load_out = b;
    repeat (4) @(negedge clk_in);
    preload_shift_clock_out = 1'h1;
    repeat (4) @(negedge clk_in);
    preload_shift_clock_out = 1'h0;
    // data no longer held after the edge
    serial_load_out = ~b;
  endtask : shift_bit
endmodule : mrpc_tester

// ---- testbench.sv ----
// self-checking bench for the macrocell register preload chain
`timescale 1ns/100ps
module testbench;
  import mrpc_pkg::*;
  localparam int N = 8;
  localparam int CLR = 20;
  logic clk_in = 1'h0;
  logic rst_in = 1'h1;
  logic sync_cell = 1'h0;
  logic glob_cell = 1'h1;
  logic [N-1:0] local_cell = 8'h5a;
  logic [N-1:0] pol_cell = 8'h0f;
  logic goe_n = 1'h1;
  logic [N-1:0] sum = 8'h33;
  logic [N-1:0] oe_term = 8'h18;
  logic [N-1:0] pin_level = 8'h96;
  logic stall = 1'h0;
  logic psel, pclk, pdata, ready, soe, svalid, done, active, sdata;
  logic [N-1:0] pin, pin_oe, mask, mreg;
  logic [2*N-1:0] lines;
  logic [3:0] clen;
  int errors = 0;
  int checked = 0;

  always #10 clk_in = ~clk_in;

  mrpc_chain #(.N(N), .CLEAR_CYCLES(CLR)) dut (
    .clk_in(clk_in), .rst_in(rst_in), .preload_select_in(psel), .preload_shift_clock_in(pclk),
    .serial_load_in(pdata), .serial_state_out(sdata), .serial_state_oe_out(soe),
    .serial_state_valid_out(svalid), .serial_state_ready_in(ready), .sync_mode_cell_in(sync_cell),
    .global_arch_cell_in(glob_cell), .local_arch_cell_in(local_cell), .polarity_cell_in(pol_cell),
    .global_oe_n_in(goe_n), .sum_term_in(sum), .oe_term_in(oe_term), .pin_level_in(pin_level),
    .pin_out(pin), .pin_oe_out(pin_oe), .array_line_out(lines), .power_up_done_out(done),
    .preload_active_out(active), .chain_length_out(clen));

  mrpc_tester tester (
    .clk_in(clk_in), .stall_in(stall), .serial_state_oe_in(soe), .serial_state_valid_in(svalid),
    .preload_select_out(psel), .preload_shift_clock_out(pclk), .serial_load_out(pdata),
    .serial_state_ready_out(ready));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    checked++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  task automatic summarize;
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : summarize

  // chain model: lowest registered cell takes the new bit, top bit leaves
  function automatic logic shift_model(input logic b);
    logic carry;
    logic t;
    carry = b;
    for (int i = 0; i < N; i++)
      if (mask[i])
      begin
        t = mreg[i];
        mreg[i] = carry;
        carry = t;
      end
    return carry;
  endfunction : shift_model

  function automatic logic [N-1:0] exp_pin();
    return (mask & ~mreg) | (~mask & (sum ^ ~pol_cell));
  endfunction : exp_pin

  // shifts n bits, first bits kept by the model only while the buffer has room
  task automatic preload(input logic [7:0] pat, input int n, input int kept);
    logic exp[$];
    tester.got.delete();
    tester.enter(1'h1);
    check(active, 1'h1, "preload active");
    for (int i = 0; i < n; i++)
    begin
      if (i < kept)
        exp.push_back(shift_model(pat[i]));
      tester.shift_bit(pat[i]);
    end
    if (stall)
    begin
      check(svalid, 1'h1, "buffer full");
      check(sdata, exp[0], "held readback bit");
    end
    stall = 1'h0;
    repeat (8) @(negedge clk_in);
    check(tester.got.size(), exp.size(), "readback count");
    for (int i = 0; i < exp.size(); i++) check(tester.got[i], exp[i], "readback bit");
    tester.enter(1'h0);
    check(active, 1'h0, "preload left");
    check(pin, exp_pin(), "pins after preload");
  endtask : preload

  task automatic mode(input logic s, input logic g, input logic [N-1:0] l);
    sync_cell = s;
    glob_cell = g;
    local_cell = l;
    repeat (6) @(negedge clk_in);
  endtask : mode

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial
  begin
    mask = ~local_cell;
    mreg = 8'h00;
    repeat (20) @(negedge clk_in);
    check(lines, {N{2'h1}}, "array lines in reset");
    rst_in = 1'h0;
    repeat (CLR - 2) @(negedge clk_in);
    check(done, 1'h0, "clear still running");
    repeat (4) @(negedge clk_in);
    check(done, 1'h1, "clear finished");
    check(pin, exp_pin(), "cleared pins");
    check(clen, 4'h4, "chain length");
    check(pin_oe, (mask & {N{~goe_n}}) | (~mask & oe_term), "registered mode enables");
    preload(8'h0b, 4, 4);
    preload(8'h06, 4, 4);
    tester.shift_bit(1'h0);
    mreg = (mask & (sum ^ ~pol_cell)) | (~mask & mreg);
    repeat (6) @(negedge clk_in);
    check(pin, exp_pin(), "normal load");
    stall = 1'h1;
    preload(8'h05, 3, 2);
    mode(1'h1, 1'h0, 8'h0f);
    check(clen, 4'h0, "small mode length");
    check(pin_oe, 8'hf0, "small mode enables");
    check(pin & 8'hf0, (sum ^ ~pol_cell) & 8'hf0, "output polarity");
    for (int i = 0; i < 4; i++) check({lines[2*i+1], lines[2*i]}, {~pin_level[i], pin_level[i]}, "pair");
    mode(1'h1, 1'h1, 8'hff);
    check(clen, 4'h0, "medium mode length");
    check(pin_oe, oe_term, "medium mode enables");
    goe_n = 1'h0;
    mode(1'h0, 1'h1, 8'h00);
    check(clen, 4'h8, "all registered");
    check(pin_oe, 8'hff, "global enable");
    summarize();
  end

  initial
  begin
    repeat (20000) @(posedge clk_in);
    errors++;
    $display("mismatch at %0t: watchdog expired", $time);
    summarize();
  end
endmodule : testbench
